//--- logic/qpc_regs.svh
// register offsets, field positions, reset values and widths of the phase clock block
`ifndef QPC_REGS_SVH
`define QPC_REGS_SVH

// apb byte offsets
`define QPC_CFG_OFF     12'h000
`define QPC_STATUS_OFF  12'h004
`define QPC_PC_OFF      12'h008
`define QPC_IR_OFF      12'h00c
`define QPC_RETIRE_OFF  12'h010

// config fields
`define QPC_CFG_OSC_LSB  0
`define QPC_CFG_OSC_MSB  1
`define QPC_CFG_RST      2'h2

// status fields
`define QPC_ST_PHASE_LSB 0
`define QPC_ST_PHASE_MSB 1
`define QPC_ST_PIPE_LSB  2
`define QPC_ST_PIPE_MSB  3
`define QPC_ST_EXV_BIT   4

// widths and reset values
`define QPC_AW           12
`define QPC_PCW          16
`define QPC_IW           16
`define QPC_DAW          9
`define QPC_DW           8
`define QPC_PC_RST       16'h0000
`define QPC_IR_RST       16'h0000
`define QPC_PHASES       4

`endif

//--- logic/qpc_pkg.sv
// types shared by the phase clock and pipeline logic
`include "qpc_regs.svh"
package qpc_pkg;

   // oscillator mode as held in the two bit select field
   typedef enum logic [1:0] {
      QPC_LOW_FREQ_CRYSTAL_MODE = 2'b00,
      QPC_CRYSTAL_MODE          = 2'b01,
      QPC_EXTERNAL_CLOCK_MODE   = 2'b10,
      QPC_RC_OSC_MODE           = 2'b11
   } qpc_osc_mode_t;

   // pipeline occupancy
   typedef enum logic [1:0] {
      QPC_PIPE_FILL  = 2'b00,
      QPC_PIPE_RUN   = 2'b01,
      QPC_PIPE_FLUSH = 2'b10
   } qpc_pipe_t;

endpackage

//--- logic/qpc_phase_gen.sv
// two bit phase counter and its one-hot phase decode
`timescale 1ns/1ns
module qpc_phase_gen
   import qpc_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_b,
   // phases
   output logic [1:0]      phase_cnt,
   output logic            phase_one,
   output logic            phase_two,
   output logic            phase_three,
   output logic            phase_four,
   output logic            div4_clock_output
);

   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;

   // one-hot decode, exactly one phase high per count
   function automatic logic is_phase(input logic [1:0] cnt, input logic [1:0] idx);
      return cnt == idx;
   endfunction

   // counter rolls 0..3, one roll is one instruction cycle
   assign cnt_nxt = cnt_r + 2'h1;

   // reset parks the counter in phase_one
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         cnt_r <= 2'h0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign phase_cnt   = cnt_r;
   assign phase_one   = is_phase(cnt_r, 2'h0);
   assign phase_two   = is_phase(cnt_r, 2'h1);
   assign phase_three = is_phase(cnt_r, 2'h2);
   assign phase_four  = is_phase(cnt_r, 2'h3);

   // msb of the count: low in phases one/two, high in three/four
   assign div4_clock_output = cnt_r[1];

endmodule

//--- logic/qpc_core.sv
// phase clocked two stage fetch/execute pipeline with apb status and config
//
// What this block does
// - divide oscillator by four into four phases
// - program counter increments once, in phase_one
// - fetched word captured into holding register, phase_four
// - execute in the cycle after fetch
// - fetch overlaps execute, one instruction per cycle
// - branch flushes fetched word, costs two cycles
// - non-branch instructions take exactly one cycle
// - word presented phase_one, operation in phases two-four
// - operand read phase_two, destination write phase_four
// - external clock mode drives divided clock out
// - rc mode drives oscillator divided by four out
// - two bit oscillator select, external clock default
// - reset holds phase generator in phase_one
`timescale 1ns/1ns
`include "qpc_regs.svh"
module qpc_core
   import qpc_pkg::*;
(
   // oscillator clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst_b,
   // apb slave
   input  wire logic [`QPC_AW-1:0]    paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   // oscillator output pin
   output logic                       osc_output_pin_o,
   output logic                       osc_output_pin_oe,
   // phase clocks
   output logic                       phase_one,
   output logic                       phase_two,
   output logic                       phase_three,
   output logic                       phase_four,
   // program memory
   output logic [`QPC_PCW-1:0]        prog_addr,
   output logic                       prog_rd,
   input  wire logic [`QPC_IW-1:0]    prog_data,
   // data memory
   output logic [`QPC_DAW-1:0]        dmem_addr,
   output logic                       dmem_rd,
   input  wire logic [`QPC_DW-1:0]    dmem_rdata,
   output logic                       dmem_wr,
   output logic [`QPC_DW-1:0]         dmem_wdata,
   // execution datapath
   output logic [`QPC_IW-1:0]         ex_instr,
   output logic                       ex_valid,
   output logic [`QPC_DW-1:0]         ex_operand,
   input  wire logic [`QPC_DAW-1:0]   dp_addr,
   input  wire logic                  dp_write,
   input  wire logic [`QPC_DW-1:0]    dp_wdata,
   input  wire logic                  dp_branch,
   input  wire logic [`QPC_PCW-1:0]   dp_target
);

   // phase generator outputs
   logic [1:0]               phase_cnt;
   logic                     div4_clock_output;

   // pipeline state
   qpc_pipe_t                pipe_r;
   qpc_pipe_t                pipe_nxt;
   logic [`QPC_PCW-1:0]      pc_r;
   logic [`QPC_PCW-1:0]      pc_nxt;
   logic [`QPC_PCW-1:0]      prog_addr_r;
   logic [`QPC_IW-1:0]       ir_r;
   logic [`QPC_DAW-1:0]      dmem_addr_r;
   logic [`QPC_DW-1:0]       operand_r;
   logic [`QPC_DW-1:0]       wdata_r;
   logic                     wr_pend_r;
   logic [31:0]              retire_r;

   // configuration
   qpc_osc_mode_t            osc_select_field_r;

   // apb decode
   logic                     apb_access;
   logic                     apb_wr;
   logic                     hit_cfg;
   logic                     hit_status;
   logic                     hit_pc;
   logic                     hit_ir;
   logic                     hit_retire;
   logic                     hit_any;
   logic [31:0]              rd_mux;
   logic [31:0]              status_word;

   // pipeline control terms
   logic                     exec_cycle;
   logic                     take_branch;
   logic                     cycle_end;
   logic                     drive_div4_clock_output;

   // per-phase and apb strobes, decoded once and shared
   logic                     fetch_load;
   logic                     ir_load;
   logic                     op_capture;
   logic                     res_stage;
   logic                     rd_setup;
   logic                     cfg_wr;

   // one instruction cycle, one clock per phase:
   //   phase_one   pc steps; fetch and operand addresses load
   //   phase_two   operand read from data memory
   //   phase_three result and write enable staged in flops
   //   phase_four  fetch strobe, word into the holding register,
   //               branch resolved, data memory write strobe
   // the next fetch runs in the same four clocks as this execute

   // exact word match; a misaligned address hits nothing
   function automatic logic addr_hit(input logic [`QPC_AW-1:0] addr, input logic [`QPC_AW-1:0] off);
      return addr == off;
   endfunction

   // modes in which the output pin carries the divided clock
   function automatic logic mode_drives_pin(input qpc_osc_mode_t mode);
      return (mode == QPC_EXTERNAL_CLOCK_MODE) || (mode == QPC_RC_OSC_MODE);
   endfunction

   // the four phase clocks
   qpc_phase_gen u_phase (
      .clock             (clock),
      .rst_b             (rst_b),
      .phase_cnt         (phase_cnt),
      .phase_one         (phase_one),
      .phase_two         (phase_two),
      .phase_three       (phase_three),
      .phase_four        (phase_four),
      .div4_clock_output (div4_clock_output)
   );

   // oscillator output pin

   // in crystal modes the pin belongs to the resonator, so we let go;
   // driving it low there would load the crystal and stop oscillation
   assign drive_div4_clock_output = mode_drives_pin(osc_select_field_r);
   assign osc_output_pin_oe = drive_div4_clock_output;
   // period is four oscillator periods in either driving mode
   assign osc_output_pin_o  = drive_div4_clock_output & div4_clock_output;

   // pipeline sequencing

   // an instruction is executing only once the pipe has a valid word
   assign exec_cycle  = (pipe_r == QPC_PIPE_RUN);
   // a branch is judged at the very end of the execute cycle; by then the
   // sequential word is already fetched, so it is dropped, not stopped
   assign take_branch = exec_cycle & dp_branch;
   assign cycle_end   = phase_four;

   // strobes: loads land on the edge that ends the named phase
   assign fetch_load  = phase_one;
   assign ir_load     = phase_four;
   assign op_capture  = phase_two & exec_cycle;
   assign res_stage   = phase_three;
   // apb read data is picked in the setup cycle, writes in the access cycle
   assign rd_setup    = psel & ~penable & ~pwrite;
   assign cfg_wr      = apb_wr & hit_cfg;

   // pipe state changes only at the instruction cycle boundary
   always_comb begin
      pipe_nxt = pipe_r;
      if (cycle_end) begin
         case (pipe_r)
            QPC_PIPE_FILL: begin
               // first cycle after reset only fetches
               pipe_nxt = QPC_PIPE_RUN;
            end
            QPC_PIPE_RUN: begin
               // the word fetched alongside a branch is thrown away
               pipe_nxt = dp_branch ? QPC_PIPE_FLUSH : QPC_PIPE_RUN;
            end
            QPC_PIPE_FLUSH: begin
               // target fetched during the flush cycle, executes next
               pipe_nxt = QPC_PIPE_RUN;
            end
            default: begin
               // unused code: refill rather than execute a stale word
               pipe_nxt = QPC_PIPE_FILL;
            end
         endcase
      end
   end

   // pc moves on once per cycle, or jumps at the end of a taken branch;
   // the step in the flush cycle then starts from the target
   always_comb begin
      pc_nxt = pc_r;
      if (cycle_end && take_branch) begin
         pc_nxt = dp_target;
      end else if (phase_one) begin
         pc_nxt = pc_r + `QPC_PCW'(1);
      end
   end

   // pipe state, pc and fetch address
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pipe_r      <= QPC_PIPE_FILL;
         pc_r        <= `QPC_PC_RST;
         prog_addr_r <= `QPC_PC_RST;
      end else begin
         pipe_r      <= pipe_nxt;
         pc_r        <= pc_nxt;
         if (fetch_load) begin
            prog_addr_r <= pc_r;
         end
      end
   end

   // holding register: fetched word lands at the end of phase_four
   // and is what the datapath decodes from phase_one onward
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ir_r <= `QPC_IR_RST;
      end else if (ir_load) begin
         ir_r <= prog_data;
      end
   end

   // program memory is read for the whole of phase_four; the address
   // is stable from phase_two, so memory has three clocks to answer
   assign prog_addr = prog_addr_r;
   assign prog_rd   = phase_four;

   // data memory access within the execute cycle

   // operand address settles from the decoded word during phase_one;
   // loaded in every cycle, only the strobes care whether the pipe is full
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         dmem_addr_r <= '0;
      end else if (fetch_load) begin
         dmem_addr_r <= dp_addr;
      end
   end

   // operand captured at the end of phase_two;
   // held through fill and flush cycles so they cannot corrupt it
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         operand_r <= '0;
      end else if (op_capture) begin
         operand_r <= dmem_rdata;
      end
   end

   // result staged in phase_three so phase_four has it from a flop;
   // the write strobe never sees a datapath value still moving
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         wdata_r   <= '0;
         wr_pend_r <= 1'b0;
      end else if (res_stage) begin
         wdata_r   <= dp_wdata;
         wr_pend_r <= exec_cycle & dp_write;
      end
   end

   assign dmem_addr  = dmem_addr_r;
   // flushed or filling cycles must not touch data memory
   assign dmem_rd    = phase_two & exec_cycle;
   assign dmem_wr    = phase_four & wr_pend_r;
   assign dmem_wdata = wdata_r;

   // datapath view
   assign ex_instr   = ir_r;
   assign ex_valid   = exec_cycle;
   assign ex_operand = operand_r;

   // count of instructions executed, wraps silently;
   // flush cycles are not counted, so each branch shows one lost slot
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         retire_r <= 32'h0000_0000;
      end else if (cycle_end && exec_cycle) begin
         retire_r <= retire_r + 32'h0000_0001;
      end
   end

   // apb slave, zero wait states

   // access phase and address decode
   assign apb_access = psel & penable;
   assign apb_wr     = apb_access & pwrite;
   assign hit_cfg    = addr_hit(paddr, `QPC_CFG_OFF);
   assign hit_status = addr_hit(paddr, `QPC_STATUS_OFF);
   assign hit_pc     = addr_hit(paddr, `QPC_PC_OFF);
   assign hit_ir     = addr_hit(paddr, `QPC_IR_OFF);
   assign hit_retire = addr_hit(paddr, `QPC_RETIRE_OFF);
   assign hit_any    = hit_cfg | hit_status | hit_pc | hit_ir | hit_retire;

   // every register answers from flops or live state, so no wait is needed
   assign pready  = 1'b1;
   // unmapped addresses answer with an error, writes there are dropped
   assign pslverr = apb_access & ~hit_any;

   // oscillator mode select, default is the external clock;
   // only the two low bits of the written word are kept
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         osc_select_field_r <= qpc_osc_mode_t'(`QPC_CFG_RST);
      end else if (cfg_wr) begin
         osc_select_field_r <= qpc_osc_mode_t'(pwdata[`QPC_CFG_OSC_MSB:`QPC_CFG_OSC_LSB]);
      end
   end

   // status: live phase, pipe state and execute flag
   // read-only: writes here are accepted and dropped
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`QPC_ST_PHASE_MSB:`QPC_ST_PHASE_LSB] = phase_cnt;
      status_word[`QPC_ST_PIPE_MSB:`QPC_ST_PIPE_LSB]   = pipe_r;
      status_word[`QPC_ST_EXV_BIT]                      = exec_cycle;
   end

   // read mux, zero outside the mapped words
   assign rd_mux = hit_cfg    ? {30'h0000_0000, osc_select_field_r} :
                   hit_status ? status_word :
                   hit_pc     ? {16'h0000, pc_r} :
                   hit_ir     ? {16'h0000, ir_r} :
                   hit_retire ? retire_r :
                                32'h0000_0000;

   // read data held in a flop, loaded in the setup cycle so it is
   // valid during the access cycle; status may move by one phase
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= rd_mux;
      end
   end

endmodule

//--- verif/qpc_core_assertions.sv
// concurrent checks on the phase clock and fetch pipeline ports
`timescale 1ns/1ns
`include "qpc_regs.svh"
module qpc_core_assertions (
   // clock, reset and apb
   input wire logic                 clock,
   input wire logic                 rst_b,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pslverr,
   // output pin and phases
   input wire logic                 osc_output_pin_o,
   input wire logic                 osc_output_pin_oe,
   input wire logic                 phase_one,
   input wire logic                 phase_two,
   input wire logic                 phase_three,
   input wire logic                 phase_four,
   // memories and datapath
   input wire logic [`QPC_PCW-1:0]  prog_addr,
   input wire logic [`QPC_IW-1:0]   ex_instr,
   input wire logic                 prog_rd,
   input wire logic                 dmem_rd,
   input wire logic                 dmem_wr,
   input wire logic                 ex_valid,
   input wire logic                 dp_branch
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // a flushed cycle is four empty clocks, then the target runs
   sequence s_flush;
      !ex_valid [*4] ##1 ex_valid;
   endsequence
   sequence s_quad;
      phase_one ##1 phase_two ##1 phase_three ##1 phase_four;
   endsequence
   phase_onehot_a: assert property ($onehot({phase_one, phase_two, phase_three, phase_four}))
      else $error("phases not one-hot");
   phase_order_a: assert property (phase_one |-> s_quad ##1 phase_one)
      else $error("phase order broken");
   // the reset check must run while reset is low
   reset_hold_a: assert property (disable iff (1'b0) !rst_b |=> phase_one)
      else $error("phase not held in reset");
   clk_out_a: assert property (osc_output_pin_oe |-> osc_output_pin_o == (phase_three | phase_four))
      else $error("divided clock level wrong");
   fetch_read_a: assert property (prog_rd == phase_four)
      else $error("fetch strobe off phase four");
   operand_read_a: assert property (dmem_rd |-> phase_two && ex_valid)
      else $error("operand read off phase two");
   dest_write_a: assert property (dmem_wr |-> phase_four && ex_valid)
      else $error("write off phase four");
   pc_step_a: assert property ($changed(prog_addr) && $past(rst_b) |-> $past(phase_one))
      else $error("fetch address moved off phase one");
   ir_load_a: assert property ($changed(ex_instr) && $past(rst_b) |-> phase_one)
      else $error("holding register moved off phase one");
   branch_flush_a: assert property (phase_four && ex_valid && dp_branch |=> s_flush)
      else $error("branch flush wrong");
   single_cycle_a: assert property (phase_four && ex_valid && !dp_branch |=> ex_valid [*4])
      else $error("plain instruction stalled");
   slverr_phase_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
endmodule
bind qpc_core qpc_core_assertions chk_u (.*);

//--- verif/qpc_mem_model.sv
// program and data memory model at the far side of the pipeline
`timescale 1ns/1ns
package qpc_mem_pkg;
   function automatic logic [15:0] qpc_pword(input logic [15:0] a);
      return {a[7:0] ^ 8'h5a, a[15:8] + 8'h3c};
   endfunction
   function automatic logic [7:0] qpc_dbyte(input logic [8:0] a);
      return a[7:0] ^ {a[8], 7'h2b};
   endfunction
endpackage
module qpc_mem_model
   import qpc_mem_pkg::*;
(
   // clock
   input  wire logic        clock,
   // program memory
   input  wire logic [15:0] prog_addr,
   input  wire logic        prog_rd,
   output logic [15:0]      prog_data,
   // data memory
   input  wire logic [8:0]  dmem_addr,
   input  wire logic        dmem_rd,
   output logic [7:0]       dmem_rdata
);
   logic [15:0] junk_r = 16'h0f0f;
   // idle buses change every cycle so a late sample cannot pass
   always_ff @(posedge clock) junk_r <= ~junk_r + 16'h0001;
   // answer only while the strobe is up
   assign prog_data  = prog_rd ? qpc_pword(prog_addr) : junk_r;
   assign dmem_rdata = dmem_rd ? qpc_dbyte(dmem_addr) : junk_r[7:0];
endmodule

//--- verif/testbench.sv
// self-checking bench for the phase clock and pipeline block
`timescale 1ns/1ns
`include "qpc_regs.svh"
module testbench
   import qpc_mem_pkg::*;
;
   logic clock, rst_b, psel, penable, pwrite, pready, pslverr, osc_output_pin_o, osc_output_pin_oe;
   logic phase_one, phase_two, phase_three, phase_four, prog_rd, dmem_rd, dmem_wr, ex_valid;
   logic dp_write, dp_branch, vld, wen, run, rnd, brall, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] prog_addr, prog_data, ex_instr, dp_target, pc, fa, ei;
   logic [8:0]  dmem_addr, dp_addr, da;
   logic [7:0]  dmem_rdata, dmem_wdata, ex_operand, dp_wdata, wd;
   logic [1:0]  mode;
   int          seed, ph, i, n_fail, checked;
   qpc_core dut_u (.*);
   qpc_mem_model mem_u (.*);
   always #5 clock = ~clock;
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      checked++;
      if (g !== x) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic stop_test;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // one apb transfer; waits on pready, bounded
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clock);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         n_fail++;
         stop_test;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // random datapath requests
   always @(posedge clock) if (rnd) begin
      dp_addr   <= 9'($random(seed));
      dp_write  <= 1'($random(seed));
      dp_wdata  <= 8'($random(seed));
      dp_branch <= brall | (($random(seed) & 3) == 0);
      dp_target <= 16'($random(seed));
   end
   // expected pipeline state, fed only by bench-driven inputs
   always @(posedge clock) begin
      if (!rst_b) begin
         ph = 0; pc = 0; vld = 0; wen = 0; run = 1; mode = 2'h2;
      end else begin
         if (ph == 0) begin
            fa = pc; pc = pc + 16'h0001; da = dp_addr;
         end
         if (ph == 2) begin
            wd = dp_wdata; wen = vld & dp_write;
         end
         if (ph == 3) begin
            ei = qpc_pword(fa);
            if (vld & dp_branch) pc = dp_target;
            vld = !(vld & dp_branch);
         end
         ph = (ph + 1) % 4;
      end
   end
   // outputs are settled at the falling edge
   always @(negedge clock) if (run) begin
      chk("phases", 4'b0001 << ph, {phase_four, phase_three, phase_two, phase_one});
      chk("ex_valid", vld, ex_valid);
      chk("prog_rd", ph == 3, prog_rd);
      chk("dmem_rd", vld && ph == 1, dmem_rd);
      chk("dmem_wr", wen && ph == 3, dmem_wr);
      chk("osc_oe", mode[1], osc_output_pin_oe);
      if (mode[1]) chk("osc_out", ph >= 2, osc_output_pin_o);
      if (mode == 2'h3) chk("rc div4_clock_output", ph >= 2, osc_output_pin_o);
      if (rst_b && ph == 3) chk("prog_addr", fa, prog_addr);
      if (vld) begin
         chk("ex_instr", ei, ex_instr);
         if (ph == 1) chk("dmem_addr", da, dmem_addr);
         if (ph >= 2) chk("operand", qpc_dbyte(da), ex_operand);
         if (wen && ph == 3) chk("wdata", wd, dmem_wdata);
      end
   end
   initial begin
      seed = 32'h4b32; clock = 0; rst_b = 0; psel = 0; penable = 0; pwrite = 0;
      paddr = 0; pwdata = 0; rnd = 0; brall = 0; run = 0; mode = 2'h2;
      dp_addr = 0; dp_write = 0; dp_wdata = 0; dp_branch = 0; dp_target = 0;
      n_fail = 0; checked = 0;
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      apb(1'b0, `QPC_CFG_OFF, 0);
      chk("cfg reset", 2, q);
      $display("test reset done");
      // every oscillator mode, with the pin watched meanwhile
      for (i = 0; i < 4; i++) begin
         apb(1'b1, `QPC_CFG_OFF, i);
         mode = 2'(i);
         apb(1'b0, `QPC_CFG_OFF, 0);
         chk("cfg mode", i, q);
         repeat (8) @(posedge clock);
      end
      apb(1'b0, 12'h020, 0);
      chk("unmapped err", 1, e);
      chk("unmapped data", 0, q);
      $display("test modes done");
      rnd = 1;
      repeat (400) @(posedge clock);
      brall = 1; // back-to-back branches
      repeat (40) @(posedge clock);
      brall = 0;
      $display("test pipeline done");
      @(posedge clock);
      rst_b <= 1'b0; // reset in mid-run
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      repeat (60) @(posedge clock);
      $display("test rerun done");
      stop_test;
   end
endmodule
